// *** pkg/pps_regs.vh ***
// Register offsets, field positions, reset values and timing constants
// for the port power and fault status bank.
// Assumes inclusion by bare name from the design files.
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PPS_POWER_FLAGS_OFS  8'h1e
`define PPS_FAULT_FLAGS_OFS  8'h1f

// ----------------------------------------------------------------------
// Power flags fields
// ----------------------------------------------------------------------
`define PPS_PWR_DEBUG_ACC    7
`define PPS_PWR_INIT_PEND    6
`define PPS_PWR_SRC_HIGH     5
`define PPS_PWR_SRC_BUS      4
`define PPS_PWR_DET_ON       3
`define PPS_PWR_BUS_PRES     2
`define PPS_PWR_CABLE_PRES   1
`define PPS_PWR_SINK_BUS     0

// ----------------------------------------------------------------------
// Fault flags fields
// ----------------------------------------------------------------------
`define PPS_FLT_FORCED_OFF   6
`define PPS_FLT_AUTO_FAIL    5
`define PPS_FLT_FORCED_FAIL  4
`define PPS_FLT_CABLE_OC     1
`define PPS_FLT_LINK_ERR     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PPS_POWER_RST        8'h00
`define PPS_FAULT_RST        8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPS_CLK_MHZ          25
`define PPS_SAFE0_TIME_US    1000
`define PPS_DRAIN_CYC        (`PPS_SAFE0_TIME_US * `PPS_CLK_MHZ)

// Default 7-bit link address (arbitrary value)
`define PPS_DEV_ADDR         7'h20

`endif

// *** src/pps_sync.v ***
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence implied.
`timescale 1ns/1ps
module pps_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Levels
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

endmodule // pps_sync

// *** src/pps_drain_timer.v ***
// Discharge supervisor: runs a discharge until the bus reaches the safe
// zero level, flags a failure if that takes longer than the limit.
// Assumes start is a one-cycle pulse and safe0 is already synchronised.
`timescale 1ns/1ps
module pps_drain_timer #(
  parameter        CW    = 24,
  parameter [CW-1:0] LIMIT = 24'd25000
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Control
  input  wire start,
  input  wire safe0,
  // Status
  output reg  active_q,
  output reg  fail_q
);

  reg [CW-1:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      fail_q   <= 1'b0;
      cnt_q    <= {CW{1'b0}};
    end else begin
      fail_q <= 1'b0;
      if (start && !active_q) begin
        active_q <= 1'b1;
        cnt_q    <= {CW{1'b0}};
      end else if (active_q) begin
        if (safe0) begin
          active_q <= 1'b0;
        end else if (cnt_q >= LIMIT - 1'b1) begin
          // Give up so a stuck bus does not hold the drain on forever
          active_q <= 1'b0;
          fail_q   <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule // pps_drain_timer

// *** src/pps_top.v ***
// Port power and fault status bank with its two-wire link slave.
// Assumes analog comparator results arrive as asynchronous levels and
// that the link clock is slow enough to be oversampled by clk.
`timescale 1ns/1ps
`include "pps_regs.vh"

module pps_top #(
  parameter [6:0]  DEV_ADDR  = `PPS_DEV_ADDR,
  parameter        DRAIN_CYC = `PPS_DRAIN_CYC
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Two-wire link
  input  wire scl,
  input  wire sda_in,
  output reg  sda_out_q,
  output reg  sda_oe_q,
  // Analog monitor levels (asynchronous)
  input  wire debug_acc_det,
  input  wire src_high_volt,
  input  wire src_bus_en,
  input  wire det_on,
  input  wire bus_above_4v,
  input  wire bus_above_3v5,
  input  wire cc1_above_2v4,
  input  wire cc2_above_2v4,
  input  wire sink_bus_en,
  input  wire bus_safe0,
  input  wire cable_oc,
  input  wire cable_sw_closed,
  // Configuration levels from the control bank (asynchronous)
  input  wire auto_drain_en,
  input  wire sink_thr_zero,
  input  wire forced_drain_req,
  // Same-clock event from the transmit logic
  input  wire tx_empty_cmd,
  // Power path
  output reg  drain_q
);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  localparam NS = 17;
  wire [NS-1:0] raw_in = {scl, sda_in, debug_acc_det, src_high_volt,
                          src_bus_en, det_on, bus_above_4v, bus_above_3v5,
                          cc1_above_2v4, cc2_above_2v4, sink_bus_en,
                          bus_safe0, cable_oc, cable_sw_closed,
                          auto_drain_en, sink_thr_zero, forced_drain_req};
  wire [NS-1:0] s;

  pps_sync #(.W(NS)) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .async_i (raw_in),
    .sync_q  (s)
  );

  wire scl_s, sda_s, dbg_s, hv_s, srcen_s, deton_s;
  wire hi_s, lo_s, cc1_s, cc2_s, sink_s, safe0_s;
  wire oc_s, swc_s, auto_s, thrz_s, force_s;
  assign {scl_s, sda_s, dbg_s, hv_s, srcen_s, deton_s, hi_s, lo_s,
          cc1_s, cc2_s, sink_s, safe0_s, oc_s, swc_s, auto_s, thrz_s,
          force_s} = s;

  // --------------------------------------------------------------------
  // Power flags
  // --------------------------------------------------------------------
  reg  [7:0] power_q;
  reg        bus_pres_q;
  reg        force_p_q;
  wire       bus_pres_d;
  wire       cable_pres = cc1_s | cc2_s;

  // Hysteresis: hold between thresholds; detector off reports absent
  assign bus_pres_d = !deton_s ? 1'b0 :
                      hi_s     ? 1'b1 :
                      !lo_s    ? 1'b0 : bus_pres_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_q    <= `PPS_POWER_RST;
      bus_pres_q <= 1'b0;
      force_p_q  <= 1'b0;
    end else begin
      bus_pres_q <= bus_pres_d;
      force_p_q  <= force_s;
      // Sampled every cycle from hardware levels only, except init pending, which is held at zero
      power_q[`PPS_PWR_DEBUG_ACC]  <= dbg_s;
      power_q[`PPS_PWR_INIT_PEND]  <= 1'b0;
      power_q[`PPS_PWR_SRC_HIGH]   <= hv_s;
      power_q[`PPS_PWR_SRC_BUS]    <= srcen_s;
      power_q[`PPS_PWR_DET_ON]     <= deton_s;
      power_q[`PPS_PWR_BUS_PRES]   <= bus_pres_q;
      power_q[`PPS_PWR_CABLE_PRES] <= cable_pres;
      power_q[`PPS_PWR_SINK_BUS]   <= sink_s;
    end
  end

  // --------------------------------------------------------------------
  // Discharge control
  // --------------------------------------------------------------------
  wire auto_start  = bus_pres_q & ~bus_pres_d & thrz_s & auto_s;
  wire force_start = force_s & ~force_p_q;
  wire auto_act;
  wire auto_fail;
  wire force_act;
  wire force_fail;

  pps_drain_timer #(.CW(24), .LIMIT(DRAIN_CYC[23:0])) u_auto (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (auto_start),
    .safe0    (safe0_s),
    .active_q (auto_act),
    .fail_q   (auto_fail)
  );

  pps_drain_timer #(.CW(24), .LIMIT(DRAIN_CYC[23:0])) u_force (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (force_start),
    .safe0    (safe0_s),
    .active_q (force_act),
    .fail_q   (force_fail)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_q <= 1'b0;
    end else begin
      drain_q <= auto_act | force_act;
    end
  end

  // --------------------------------------------------------------------
  // Fault flags
  // --------------------------------------------------------------------
  reg  [7:0] fault_q;
  reg        wr_fault_q;
  reg  [7:0] wr_data_q;
  wire [7:0] flt_set;
  wire [7:0] flt_clr = wr_fault_q ? wr_data_q : 8'h00;

  // Forced-off and the bus protection bits have no source here
  assign flt_set[7]                   = 1'b0;
  assign flt_set[`PPS_FLT_FORCED_OFF] = 1'b0;
  assign flt_set[`PPS_FLT_AUTO_FAIL]  = auto_fail;
  assign flt_set[`PPS_FLT_FORCED_FAIL] = force_fail;
  assign flt_set[3:2]                 = 2'b00;
  assign flt_set[`PPS_FLT_CABLE_OC]   = oc_s | (swc_s & ~cable_pres);
  assign flt_set[`PPS_FLT_LINK_ERR]   = tx_empty_cmd;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= `PPS_FAULT_RST;
    end else begin
      // Write one to clear; a set in the same cycle wins
      fault_q <= (fault_q & ~flt_clr) | flt_set;
    end
  end

  // --------------------------------------------------------------------
  // Link slave
  // --------------------------------------------------------------------
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_AACK = 9'h004;
  localparam [8:0] S_PTR  = 9'h008;
  localparam [8:0] S_PACK = 9'h010;
  localparam [8:0] S_WR   = 9'h020;
  localparam [8:0] S_RD   = 9'h040;
  localparam [8:0] S_RACK = 9'h080;
  localparam [8:0] S_WACK = 9'h100;

  reg  [8:0] st_q;
  reg        scl_p_q;
  reg        sda_p_q;
  reg  [7:0] sh_q;
  reg  [3:0] cnt_q;
  reg        rw_q;
  reg        nack_q;
  reg  [7:0] ptr_q;
  reg  [7:0] rs_q;
  reg  [7:0] rd_val;

  wire scl_r  = scl_s & ~scl_p_q;
  wire scl_f  = ~scl_s & scl_p_q;
  wire start  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Power flags have no write path at all
  always @* begin
    if (ptr_q == `PPS_POWER_FLAGS_OFS) begin
      rd_val = power_q;
    end else if (ptr_q == `PPS_FAULT_FLAGS_OFS) begin
      rd_val = fault_q;
    end else begin
      rd_val = 8'h00;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= S_IDLE;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      sh_q       <= 8'h00;
      cnt_q      <= 4'h0;
      rw_q       <= 1'b0;
      nack_q     <= 1'b0;
      ptr_q      <= 8'h00;
      rs_q       <= 8'h00;
      sda_out_q  <= 1'b0;
      sda_oe_q   <= 1'b0;
      wr_fault_q <= 1'b0;
      wr_data_q  <= 8'h00;
    end else begin
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
      wr_fault_q <= 1'b0;
      if (start) begin
        st_q     <= S_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop) begin
        st_q     <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        if (scl_r && (st_q == S_ADDR || st_q == S_PTR || st_q == S_WR)) begin
          sh_q  <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
        case (st_q)
          S_ADDR: begin
            if (scl_f && cnt_q == 4'h8) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rw_q     <= sh_q[0];
                sda_oe_q <= 1'b1;
                st_q     <= S_AACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_f) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                rs_q     <= rd_val;
                sda_oe_q <= ~rd_val[7];
                st_q     <= S_RD;
              end else begin
                sda_oe_q <= 1'b0;
                st_q     <= S_PTR;
              end
            end
          end
          S_PTR: begin
            if (scl_f && cnt_q == 4'h8) begin
              ptr_q    <= sh_q;
              sda_oe_q <= 1'b1;
              st_q     <= S_PACK;
            end
          end
          S_WR: begin
            if (scl_f && cnt_q == 4'h8) begin
              wr_fault_q <= (ptr_q == `PPS_FAULT_FLAGS_OFS);
              wr_data_q  <= sh_q;
              ptr_q      <= ptr_q + 8'h01;
              sda_oe_q   <= 1'b1;
              st_q       <= S_WACK;
            end
          end
          S_PACK, S_WACK: begin
            if (scl_f) begin
              sda_oe_q <= 1'b0;
              cnt_q    <= 4'h0;
              st_q     <= S_WR;
            end
          end
          S_RD: begin
            if (scl_f) begin
              if (cnt_q == 4'h7) begin
                sda_oe_q <= 1'b0;
                ptr_q    <= ptr_q + 8'h01;
                st_q     <= S_RACK;
              end else begin
                rs_q     <= {rs_q[6:0], 1'b0};
                sda_oe_q <= ~rs_q[6];
                cnt_q    <= cnt_q + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_r) begin
              nack_q <= sda_s;
            end
            if (scl_f) begin
              if (nack_q) begin
                st_q <= S_IDLE;
              end else begin
                rs_q     <= rd_val;
                sda_oe_q <= ~rd_val[7];
                cnt_q    <= 4'h0;
                st_q     <= S_RD;
              end
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // pps_top

// *** testbench/pps_assertions.sv ***
// Concurrent checks on the link pins and the discharge output.
// Assumes it is bound into pps_top and sees only its ports.
`timescale 1ns/1ps
module pps_checker #(
  parameter DRAIN_CYC = 50
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Link
  input wire scl,
  input wire sda_out_q,
  input wire sda_oe_q,
  // Discharge causes and result
  input wire det_on,
  input wire bus_above_4v,
  input wire bus_above_3v5,
  input wire sink_thr_zero,
  input wire auto_drain_en,
  input wire forced_drain_req,
  input wire bus_safe0,
  input wire drain_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Presence from raw levels, ahead of the design's sync stages
  reg        pres_q;
  reg [15:0] run_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pres_q <= 1'b0;
      run_q  <= 16'h0000;
    end else begin
      pres_q <= det_on && (bus_above_4v || (pres_q && bus_above_3v5));
      run_q  <= drain_q ? run_q + 16'h0001 : 16'h0000;
    end
  end
  sequence s_pres_fall;
    pres_q ##1 !pres_q && det_on && sink_thr_zero && auto_drain_en;
  endsequence
  sequence s_bus_wet;
    !bus_safe0 [*8];
  endsequence
  a_sda_open_drain: assert property (!sda_out_q)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_q) |-> !scl && !$past(scl))
    else $error("data drive moved with clock high");
  a_oe_after_fall: assert property ($fell(scl) |=> $stable(sda_oe_q))
    else $error("data drive moved too soon");
  a_quiet_reset: assert property ($rose(rst_n) |-> !sda_oe_q [*3])
    else $error("data driven after reset");
  a_drain_start:
    assert property (s_pres_fall ##1 s_bus_wet |-> drain_q)
    else $error("discharge not started");
  a_drain_cause:
    assert property ($rose(drain_q) |->
      $past(auto_drain_en, 2) || $past(forced_drain_req, 2))
    else $error("discharge without cause");
  a_drain_dry_stop: assert property (bus_safe0 [*6] |-> !drain_q)
    else $error("discharge beyond safe level");
  a_drain_bounded: assert property (run_q <= DRAIN_CYC + 4)
    else $error("discharge too long");
  a_drain_full:
    assert property ($fell(drain_q) |->
      $past(run_q) >= DRAIN_CYC - 2 || $past(bus_safe0, 2))
    else $error("discharge cut short");
endmodule // pps_checker
bind pps_top pps_checker #(.DRAIN_CYC(DRAIN_CYC)) i_pps_checker (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sda_out_q(sda_out_q),
  .sda_oe_q(sda_oe_q), .det_on(det_on), .bus_above_4v(bus_above_4v),
  .bus_above_3v5(bus_above_3v5), .sink_thr_zero(sink_thr_zero),
  .auto_drain_en(auto_drain_en), .forced_drain_req(forced_drain_req),
  .bus_safe0(bus_safe0), .drain_q(drain_q));

// *** testbench/pps_host.sv ***
// Two-wire host model that reads and writes the status bank.
// Assumes a pull-up on the data line; lines move at clk falling edges.
`timescale 1ns/1ps
module pps_host (
  // Clock
  input  wire clk,
  // Link lines
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  // Extra low-phase cycles; nonzero plays a slow host
  integer gap;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    gap     = 0;
  end
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves only with the clock low; device answers 3 clk after fall
  task bit_io(input logic b, output logic r);
    tick(2 + gap);
    sda_low = !b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask
  // Late release so a device still acking cannot fake a stop
  task start;
    tick(3);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task stop;
    tick(2);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task xfer(input logic [7:0] d, input logic nack,
            output logic [7:0] q, output logic ack);
    integer i;
    logic   r;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nack, r);
    ack = !r;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] o, v, output logic ok);
    logic [7:0] x;
    logic       k1, k2, k3;
    start;
    xfer({a, 1'b0}, 1'b1, x, k1);
    xfer(o, 1'b1, x, k2);
    xfer(v, 1'b1, x, k3);
    stop;
    ok = k1 & k2 & k3;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] o,
          output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic       k1, k2, k3, k4;
    start;
    xfer({a, 1'b0}, 1'b1, x, k1);
    xfer(o, 1'b1, x, k2);
    start;
    xfer({a, 1'b1}, 1'b1, x, k3);
    xfer(8'hff, 1'b1, q, k4);
    stop;
    ok = k1 & k2 & k3;
  endtask
  // Two bytes in one read: host acks the first, nacks the second
  task rd2(input logic [6:0] a, input logic [7:0] o,
           output logic [7:0] q0, q1, output logic ok);
    logic [7:0] x;
    logic       k1, k2, k3, k4;
    start;
    xfer({a, 1'b0}, 1'b1, x, k1);
    xfer(o, 1'b1, x, k2);
    start;
    xfer({a, 1'b1}, 1'b1, x, k3);
    xfer(8'hff, 1'b0, q0, k4);
    xfer(8'hff, 1'b1, q1, k4);
    stop;
    ok = k1 & k2 & k3;
  endtask
endmodule // pps_host

// *** testbench/tb.sv ***
// Self-checking bench for the port power and fault status bank.
// Assumes pps_top, pps_host and the bound checker are compiled.
`timescale 1ns/1ps
`include "pps_regs.vh"
module tb;
  localparam [7:0]  PWR = `PPS_POWER_FLAGS_OFS;
  localparam [7:0]  FLT = `PPS_FAULT_FLAGS_OFS;
  localparam [6:0]  ADR = `PPS_DEV_ADDR;
  // Power flags for each single monitor level, lv[8] down to lv[0]
  localparam [71:0] ONE = {8'h80, 8'h20, 8'h10, 8'h08, 8'h00,
                           8'h00, 8'h02, 8'h02, 8'h01};
  reg         clk, rst_n, bus_safe0, cable_oc, cable_sw_closed;
  reg         auto_drain_en, sink_thr_zero, forced_drain_req;
  reg         tx_empty_cmd;
  reg  [8:0]  lv;
  wire        scl, sda_low, sda_out_q, sda_oe_q, drain_q;
  wire        sda = !(sda_low || (sda_oe_q && !sda_out_q));
  wire        dbg_l, hv_l, srcen_l, deton_l, hi_l, lo_l, cc1_l, cc2_l;
  wire        sink_l;
  integer     error_cnt, n_tests, i;
  logic [7:0] q, q2;
  logic       ok;
  assign {dbg_l, hv_l, srcen_l, deton_l, hi_l, lo_l, cc1_l, cc2_l,
          sink_l} = lv;
  pps_top #(.DRAIN_CYC(50)) i_pps_top (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .debug_acc_det(dbg_l), .src_high_volt(hv_l), .src_bus_en(srcen_l),
    .det_on(deton_l), .bus_above_4v(hi_l), .bus_above_3v5(lo_l),
    .cc1_above_2v4(cc1_l), .cc2_above_2v4(cc2_l), .sink_bus_en(sink_l),
    .bus_safe0(bus_safe0), .cable_oc(cable_oc),
    .cable_sw_closed(cable_sw_closed), .auto_drain_en(auto_drain_en),
    .sink_thr_zero(sink_thr_zero), .forced_drain_req(forced_drain_req),
    .tx_empty_cmd(tx_empty_cmd), .drain_q(drain_q));
  pps_host i_pps_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    n_tests = n_tests + 1;
    if (seen !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task rdc(input logic [7:0] o, input logic [7:0] e, input string nm);
    i_pps_host.rd(ADR, o, q, ok);
    check(nm, q, e);
    check("read ack", {7'h00, ok}, 8'h01);
  endtask
  task wrc(input logic [7:0] o, input logic [7:0] v);
    i_pps_host.wr(ADR, o, v, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask
  task conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard, about twice the expected run
  initial begin
    #3000000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    {rst_n, bus_safe0, cable_oc, cable_sw_closed, tx_empty_cmd} = 5'h00;
    {auto_drain_en, sink_thr_zero, forced_drain_req} = 3'h0;
    lv = 9'h000;
    error_cnt = 0;
    n_tests = 0;
    i_pps_host.tick(4);
    rst_n = 1'b1;
    i_pps_host.tick(4);
    rdc(PWR, 8'h00, "power reset");
    rdc(FLT, 8'h00, "fault reset");
    for (i = 0; i < 9; i = i + 1) begin
      lv = 9'h001 << i;
      rdc(PWR, ONE[8*i+:8], "one");
    end
    lv = 9'h1ff;
    rdc(PWR, 8'hbf, "all");
    wrc(PWR, 8'h00);
    rdc(PWR, 8'hbf, "after write");
    lv = 9'h020;
    i_pps_host.tick(25000); // Detection settles before presence is read
    check("no drain", {7'h00, drain_q}, 8'h00);
    rdc(PWR, 8'h08, "absent");
    lv = 9'h028;
    rdc(PWR, 8'h08, "below set");
    lv = 9'h038;
    rdc(PWR, 8'h0c, "present");
    auto_drain_en = 1'b1;
    sink_thr_zero = 1'b1;
    lv = 9'h020;
    i_pps_host.tick(10);
    check("drain on", {7'h00, drain_q}, 8'h01);
    rdc(FLT, 8'h20, "auto fail");
    forced_drain_req = 1'b1;
    rdc(FLT, 8'h30, "forced fail");
    wrc(FLT, 8'h20);
    rdc(FLT, 8'h10, "clear one");
    wrc(FLT, 8'h10);
    forced_drain_req = 1'b0;
    lv = 9'h038;
    i_pps_host.tick(10);
    lv = 9'h020;
    i_pps_host.tick(10);
    bus_safe0 = 1'b1;
    i_pps_host.tick(8);
    check("drain off", {7'h00, drain_q}, 8'h00);
    rdc(FLT, 8'h00, "no fail");
    cable_oc = 1'b1;
    i_pps_host.tick(4);
    cable_oc = 1'b0;
    rdc(FLT, 8'h02, "overcurrent");
    wrc(FLT, 8'h02);
    cable_sw_closed = 1'b1;
    i_pps_host.tick(4);
    lv = 9'h024;
    rdc(FLT, 8'h02, "cable lost");
    wrc(FLT, 8'h02);
    rdc(FLT, 8'h00, "cable held");
    tx_empty_cmd = 1'b1;
    @(negedge clk);
    tx_empty_cmd = 1'b0;
    rdc(FLT, 8'h01, "link error");
    rst_n = 1'b0;
    i_pps_host.tick(4);
    rst_n = 1'b1;
    i_pps_host.tick(4);
    rdc(FLT, 8'h00, "fault after reset");
    rdc(8'h05, 8'h00, "unmapped");
    i_pps_host.rd2(ADR, PWR, q, q2, ok);
    check("burst power", q, 8'h0a);
    check("burst fault", q2, 8'h00);
    check("burst ack", {7'h00, ok}, 8'h01);
    i_pps_host.rd(7'h21, PWR, q, ok);
    check("foreign address ack", {7'h00, ok}, 8'h00);
    i_pps_host.gap = 6;
    rdc(PWR, 8'h0a, "slow host");
    conclude;
  end
endmodule // tb
